// ===== hw/pfrc_pkg.sv
package pfrc_pkg;

  // serial control word
  localparam int unsigned WORD_W          = 24;
  localparam int unsigned ADDR_W          = 4;
  localparam logic [3:0]  ADDR_FASTLOCK   = 4'hD;
  localparam logic [3:0]  ADDR_RESET_TRI  = 4'hF;

  // fastlock word fields
  localparam int unsigned CSR_LSB         = 22;
  localparam int unsigned CSR_W           = 2;
  localparam int unsigned CPF_LSB         = 18;
  localparam int unsigned CPF_W           = 4;
  localparam int unsigned TOC_LSB         = 4;
  localparam int unsigned TOC_W           = 14;
  localparam int unsigned FL_CNT_W        = TOC_W + 1;
  localparam int unsigned GAIN_W          = CPF_W + 1;

  // timeout field codes
  localparam logic [13:0] TOC_HIZ         = 14'h0000;
  localparam logic [13:0] TOC_MANUAL      = 14'h0001;
  localparam logic [13:0] TOC_DRIVE_LOW   = 14'h0002;
  localparam logic [13:0] TOC_DRIVE_HIGH  = 14'h0003;
  localparam logic [13:0] TOC_TIMED_MIN   = 14'h0004;

  // cycle slip codes
  localparam logic [1:0]  CSR_OFF         = 2'h0;
  localparam logic [1:0]  CSR_HALF        = 2'h1;
  localparam logic [1:0]  CSR_QUARTER     = 2'h2;
  localparam logic [1:0]  CSR_SIXTEENTH   = 2'h3;
  localparam int unsigned CSR_CNT_W       = 4;

  // reset / tri-state word fields
  localparam int unsigned LDQ_BIT         = 13;
  localparam int unsigned AUX_RST_BIT     = 7;
  localparam int unsigned MAIN_RST_BIT    = 6;
  localparam int unsigned AUX_TRI_BIT     = 5;
  localparam int unsigned MAIN_TRI_BIT    = 4;
  localparam logic [9:0]  RT_HIGH_FIXED   = 10'h000;
  localparam logic [4:0]  RT_MID_FIXED    = 5'h09;
  localparam int unsigned LD_DIV_W        = 2;

  // reset values
  localparam logic [13:0] TOC_RST         = 14'h0000;
  localparam logic [3:0]  CPF_RST         = 4'h0;
  localparam logic [1:0]  CSR_RST         = 2'h0;
  localparam logic        BIT_RST         = 1'b0;

  // power-up counter reset length in mclk cycles
  localparam int unsigned PWRUP_RST_CYC   = 8;
  localparam int unsigned PWRUP_CNT_W     = 4;

  typedef enum logic [1:0]
  {
    FL_IDLE   = 2'b00,
    FL_TIMED  = 2'b01,
    FL_MANUAL = 2'b11
  } pfrc_fl_state_t;

endpackage

// ===== hw/pfrc_word_if.sv
`timescale 1ns/1ns
interface pfrc_word_if;
  logic [23:0] word;
  logic        valid;
  modport src (output word, output valid);
  modport dst (input word, input valid);
endinterface

// ===== hw/pfrc_serial_rx.sv
`timescale 1ns/1ns
module pfrc_serial_rx
  import pfrc_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // three-wire serial pins
  input  wire logic ser_clk,
  input  wire logic ser_data,
  input  wire logic ser_latch,
  // received words
  pfrc_word_if.src  wr
);

  logic [2:0]        clk_sync_reg;
  logic [1:0]        dat_sync_reg;
  logic [2:0]        le_sync_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] word_reg;
  logic              valid_reg;

  // two-flop synchronisers plus one history stage for edges
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      clk_sync_reg <= 3'h0;
      dat_sync_reg <= 2'h0;
      le_sync_reg  <= 3'h0;
    end
    else
    begin
      clk_sync_reg <= {clk_sync_reg[1:0], ser_clk};
      dat_sync_reg <= {dat_sync_reg[0], ser_data};
      le_sync_reg  <= {le_sync_reg[1:0], ser_latch};
    end
  end

  // msb first, data taken on rising serial clock
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      shift_reg <= '0;
    else if (clk_sync_reg[1] && !clk_sync_reg[2])
      shift_reg <= {shift_reg[WORD_W-2:0], dat_sync_reg[1]};
  end

  // word handed over on rising latch
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      word_reg  <= '0;
      valid_reg <= 1'b0;
    end
    else
    begin
      valid_reg <= le_sync_reg[1] && !le_sync_reg[2];
      if (le_sync_reg[1] && !le_sync_reg[2])
        word_reg <= shift_reg;
    end
  end

  assign wr.word  = word_reg;
  assign wr.valid = valid_reg;

endmodule

// ===== hw/pfrc_top.sv
`timescale 1ns/1ns
module pfrc_top
  import pfrc_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // three-wire serial pins
  input  wire logic              ser_clk,
  input  wire logic              ser_data,
  input  wire logic              ser_latch,
  // power-up sources
  input  wire logic              chip_enable,
  input  wire logic              sw_powerup,
  // comparison events, one-cycle pulses
  input  wire logic              main_cmp_evt,
  input  wire logic              aux_cmp_evt,
  // fastlock pin
  output logic                   fastlock_out_pin,
  output logic                   fastlock_out_pin_oe,
  // fastlock and charge pump
  output logic                   fastlock_active,
  output logic [GAIN_W-1:0]      main_fastlock_pump_gain,
  output logic [CSR_W-1:0]       cycle_slip_rate_sel,
  output logic                   main_pd_sample,
  // lock detect strobes
  output logic                   main_ld_strobe,
  output logic                   aux_ld_strobe,
  // counter reset and tri-state
  output logic                   main_counter_reset,
  output logic                   aux_counter_reset,
  output logic                   main_pump_tristate,
  output logic                   aux_pump_tristate
);

  pfrc_word_if wif ();

  pfrc_serial_rx u_rx
  (
    .mclk      (mclk),
    .rstn      (rstn),
    .ser_clk   (ser_clk),
    .ser_data  (ser_data),
    .ser_latch (ser_latch),
    .wr        (wif.src)
  );

  // sample-enable mask for the cycle-slip divider
  function automatic logic [CSR_CNT_W-1:0] csr_mask(input logic [CSR_W-1:0] code);
    case (code)
      CSR_OFF:       csr_mask = 4'h0;
      CSR_HALF:      csr_mask = 4'h1;
      CSR_QUARTER:   csr_mask = 4'h3;
      CSR_SIXTEENTH: csr_mask = 4'hF;
      default:       csr_mask = 4'h0;
    endcase
  endfunction

  logic [TOC_W-1:0]       toc_reg;
  logic [CPF_W-1:0]       cpf_reg;
  logic [CSR_W-1:0]       csr_reg;
  logic                   ldq_reg;
  logic                   aux_rst_reg;
  logic                   main_rst_reg;
  logic                   aux_tri_reg;
  logic                   main_tri_reg;
  logic                   fl_wr;
  logic                   rt_wr;
  logic [TOC_W-1:0]       wr_toc;
  pfrc_fl_state_t         fl_state_reg;
  pfrc_fl_state_t         fl_state_next;
  logic [FL_CNT_W-1:0]    fl_cnt_reg;
  logic [1:0]             ce_sync_reg;
  logic                   ce_prev_reg;
  logic [PWRUP_CNT_W-1:0] pwrup_cnt_reg;
  logic                   pwrup_evt;
  logic [CSR_CNT_W-1:0]   csr_cnt_reg;
  logic [LD_DIV_W-1:0]    ld_cnt_reg;
  logic                   fl_on;
  logic [TOC_W-1:0]       toc_cur;
  logic [CPF_W-1:0]       cpf_cur;

  // word decode
  assign wr_toc = wif.word[TOC_LSB +: TOC_W];
  assign fl_wr  = wif.valid && (wif.word[ADDR_W-1:0] == ADDR_FASTLOCK);
  assign rt_wr  = wif.valid && (wif.word[ADDR_W-1:0] == ADDR_RESET_TRI)
               && (wif.word[23:14] == RT_HIGH_FIXED)
               && (wif.word[12:8] == RT_MID_FIXED);

  // fastlock word fields
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      toc_reg <= TOC_RST;
      cpf_reg <= CPF_RST;
      csr_reg <= CSR_RST;
    end
    else if (fl_wr)
    begin
      toc_reg <= wr_toc;
      cpf_reg <= wif.word[CPF_LSB +: CPF_W];
      csr_reg <= wif.word[CSR_LSB +: CSR_W];
    end
  end

  // reset and tri-state word fields
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ldq_reg      <= BIT_RST;
      aux_rst_reg  <= BIT_RST;
      main_rst_reg <= BIT_RST;
      aux_tri_reg  <= BIT_RST;
      main_tri_reg <= BIT_RST;
    end
    else if (rt_wr)
    begin
      ldq_reg      <= wif.word[LDQ_BIT];
      aux_rst_reg  <= wif.word[AUX_RST_BIT];
      main_rst_reg <= wif.word[MAIN_RST_BIT];
      aux_tri_reg  <= wif.word[AUX_TRI_BIT];
      main_tri_reg <= wif.word[MAIN_TRI_BIT];
    end
  end

  // fastlock state
  always_comb
  begin
    fl_state_next = fl_state_reg;
    if (fl_wr)
    begin
      if (wr_toc == TOC_MANUAL)
        fl_state_next = FL_MANUAL;
      else if (wr_toc >= TOC_TIMED_MIN)
        fl_state_next = FL_TIMED;
      else
        fl_state_next = FL_IDLE;
    end
    else
    begin
      case (fl_state_reg)
        FL_IDLE:   fl_state_next = FL_IDLE;
        FL_TIMED:
          if (main_cmp_evt && fl_cnt_reg <= FL_CNT_W'(1))
            fl_state_next = FL_IDLE;
        FL_MANUAL: fl_state_next = FL_MANUAL;
        default:   fl_state_next = FL_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      fl_state_reg <= FL_IDLE;
    else
      fl_state_reg <= fl_state_next;
  end

  // timed fastlock lasts twice the timeout in comparison events
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      fl_cnt_reg <= '0;
    else if (fl_wr)
      fl_cnt_reg <= {wr_toc, 1'b0};
    else if (fl_state_reg == FL_TIMED && main_cmp_evt && fl_cnt_reg != '0)
      fl_cnt_reg <= fl_cnt_reg - FL_CNT_W'(1);
  end

  assign fl_on = (fl_state_next != FL_IDLE);

  // fields as they stand after this edge, so pin and gain move with the state
  assign toc_cur = fl_wr ? wr_toc : toc_reg;
  assign cpf_cur = fl_wr ? wif.word[CPF_LSB +: CPF_W] : cpf_reg;

  // fastlock outputs
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      fastlock_active         <= 1'b0;
      main_fastlock_pump_gain <= '0;
    end
    else
    begin
      fastlock_active <= fl_on;
      if (fl_on)
        main_fastlock_pump_gain <= {1'b0, cpf_cur} + GAIN_W'(1);
      else
        main_fastlock_pump_gain <= '0;
    end
  end

  // fastlock pin function
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      fastlock_out_pin    <= 1'b0;
      fastlock_out_pin_oe <= 1'b0;
    end
    else
    begin
      if (toc_cur == TOC_HIZ)
      begin
        fastlock_out_pin    <= 1'b0;
        fastlock_out_pin_oe <= 1'b0;
      end
      else if (toc_cur == TOC_MANUAL)
      begin
        fastlock_out_pin    <= 1'b0;
        fastlock_out_pin_oe <= 1'b1;
      end
      else if (toc_cur == TOC_DRIVE_LOW)
      begin
        fastlock_out_pin    <= 1'b0;
        fastlock_out_pin_oe <= 1'b1;
      end
      else if (toc_cur == TOC_DRIVE_HIGH)
      begin
        fastlock_out_pin    <= 1'b1;
        fastlock_out_pin_oe <= 1'b1;
      end
      else
      begin
        fastlock_out_pin    <= 1'b0;
        fastlock_out_pin_oe <= (fl_state_next == FL_TIMED);
      end
    end
  end

  // cycle-slip sample-rate reduction
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      csr_cnt_reg         <= '0;
      main_pd_sample      <= 1'b0;
      cycle_slip_rate_sel <= CSR_RST;
    end
    else
    begin
      cycle_slip_rate_sel <= csr_reg;
      if (main_cmp_evt)
        csr_cnt_reg <= csr_cnt_reg + CSR_CNT_W'(1);
      main_pd_sample <= main_cmp_evt
                     && ((csr_cnt_reg & csr_mask(csr_reg)) == '0);
    end
  end

  // lock detect strobes
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ld_cnt_reg     <= '0;
      main_ld_strobe <= 1'b0;
      aux_ld_strobe  <= 1'b0;
    end
    else
    begin
      if (main_cmp_evt)
        ld_cnt_reg <= ld_cnt_reg + LD_DIV_W'(1);
      main_ld_strobe <= main_cmp_evt && (!ldq_reg || ld_cnt_reg == '0);
      aux_ld_strobe  <= aux_cmp_evt;
    end
  end

  // power-up detection from the chip-enable pin or software
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ce_sync_reg <= 2'h0;
      ce_prev_reg <= 1'b0;
    end
    else
    begin
      ce_sync_reg <= {ce_sync_reg[0], chip_enable};
      ce_prev_reg <= ce_sync_reg[1];
    end
  end

  assign pwrup_evt = (ce_sync_reg[1] && !ce_prev_reg) || sw_powerup;

  // counter reset held for a fixed time after power-up
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      pwrup_cnt_reg <= PWRUP_CNT_W'(PWRUP_RST_CYC);
    else if (pwrup_evt)
      pwrup_cnt_reg <= PWRUP_CNT_W'(PWRUP_RST_CYC);
    else if (pwrup_cnt_reg != '0)
      pwrup_cnt_reg <= pwrup_cnt_reg - PWRUP_CNT_W'(1);
  end

  // counter reset and charge pump tri-state
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      main_counter_reset <= 1'b1;
      aux_counter_reset  <= 1'b1;
      main_pump_tristate <= 1'b1;
      aux_pump_tristate  <= 1'b1;
    end
    else
    begin
      main_counter_reset <= main_rst_reg || pwrup_evt || pwrup_cnt_reg != '0;
      aux_counter_reset  <= aux_rst_reg || pwrup_evt || pwrup_cnt_reg != '0;
      main_pump_tristate <= main_rst_reg || main_tri_reg || pwrup_evt
                         || pwrup_cnt_reg != '0;
      aux_pump_tristate  <= aux_rst_reg || aux_tri_reg || pwrup_evt
                         || pwrup_cnt_reg != '0;
    end
  end

endmodule

// ===== verif/pfrc_top_asserts.sv
`timescale 1ns/1ns
module pfrc_top_asserts
  import pfrc_pkg::*;
(
  // clock and reset
  input wire logic              mclk,
  input wire logic              rstn,
  // stimulus
  input wire logic              sw_powerup,
  input wire logic              main_cmp_evt,
  input wire logic              aux_cmp_evt,
  // outputs
  input wire logic              fastlock_out_pin,
  input wire logic              fastlock_out_pin_oe,
  input wire logic              fastlock_active,
  input wire logic [GAIN_W-1:0] main_fastlock_pump_gain,
  input wire logic [CSR_W-1:0]  cycle_slip_rate_sel,
  input wire logic              main_pd_sample,
  input wire logic              main_ld_strobe,
  input wire logic              aux_ld_strobe,
  input wire logic              main_counter_reset,
  input wire logic              aux_counter_reset,
  input wire logic              main_pump_tristate,
  input wire logic              aux_pump_tristate
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_main_reset_tri: assert property (main_counter_reset |-> main_pump_tristate)
    else $error("main reset without pump tristate");
  a_aux_reset_tri: assert property (aux_counter_reset |-> aux_pump_tristate)
    else $error("aux reset without pump tristate");
  a_fastlock_pin_low: assert property (fastlock_active |->
    fastlock_out_pin_oe && !fastlock_out_pin)
    else $error("fastlock pin not driven low");
  a_gain_in_fl: assert property (fastlock_active |->
    main_fastlock_pump_gain inside {[1:16]})
    else $error("fastlock gain out of range");
  a_gain_idle_zero: assert property (!fastlock_active |->
    main_fastlock_pump_gain == 5'h00)
    else $error("gain set outside fastlock");
  a_aux_ld_undivided: assert property (aux_cmp_evt |=> aux_ld_strobe)
    else $error("aux lock detect strobe missing");
  a_main_ld_cause: assert property (main_ld_strobe |-> $past(main_cmp_evt))
    else $error("main lock detect strobe without event");
  a_pd_sample_cause: assert property (main_pd_sample |-> $past(main_cmp_evt))
    else $error("phase detector sample without event");
  a_pd_sample_off: assert property (main_cmp_evt && cycle_slip_rate_sel == CSR_OFF |=>
    cycle_slip_rate_sel != CSR_OFF || main_pd_sample)
    else $error("event dropped with cycle slip off");
  a_powerup_reset: assert property (sw_powerup |-> ##2
    (main_counter_reset && aux_counter_reset)[*7])
    else $error("power-up counter reset missing");
  c_fastlock: cover property (fastlock_active && fastlock_out_pin_oe);
  c_powerup: cover property (sw_powerup ##2 main_counter_reset);
  c_ld_strobe: cover property (main_ld_strobe);
endmodule
bind pfrc_top pfrc_top_asserts i_asserts (.mclk, .rstn, .sw_powerup, .main_cmp_evt,
  .aux_cmp_evt, .fastlock_out_pin, .fastlock_out_pin_oe, .fastlock_active,
  .main_fastlock_pump_gain, .cycle_slip_rate_sel, .main_pd_sample, .main_ld_strobe,
  .aux_ld_strobe, .main_counter_reset, .aux_counter_reset, .main_pump_tristate,
  .aux_pump_tristate);

// ===== verif/pfrc_host_model.sv
`timescale 1ns/1ns
module pfrc_host_model
  import pfrc_pkg::*;
#(
  parameter int CMP_MHZ = 10
)
(
  // three-wire serial pins
  output logic ser_clk,
  output logic ser_data,
  output logic ser_latch
);
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_latch = 1'b0;
  end
  // msb first, link clock idle low outside frames, slow adds gaps
  task automatic send(input logic [23:0] w, input logic slow);
    #137;
    for (int i = 23; i >= 0; i--)
    begin
      ser_data = w[i];
      #400 ser_clk = 1'b1;
      #400 ser_clk = 1'b0;
      if (slow)
        #800;
    end
    #400 ser_latch = 1'b1;
    #400 ser_latch = 1'b0;
    ser_data = ~w[0];
  endtask
  // reset word with its fixed bits, quarter rate forced at high rates
  task automatic send_reset(input logic ldq, input logic [3:0] b);
    send({RT_HIGH_FIXED, ldq | (CMP_MHZ > 20), RT_MID_FIXED, b,
          ADDR_RESET_TRI}, 1'b0);
  endtask
endmodule

// ===== verif/pfrc_top_test.sv
`timescale 1ns/1ns
module pfrc_top_test
  import pfrc_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        chip_enable = 1'b0;
  logic        sw_powerup = 1'b0;
  logic        main_cmp_evt = 1'b0;
  logic        aux_cmp_evt = 1'b0;
  wire         ser_clk, ser_data, ser_latch;
  logic        pin_o, pin_oe, fl_act, pd_smp, ld_main, ld_aux;
  logic [4:0]  gain;
  logic [1:0]  csr_sel;
  logic [3:0]  rst_tri;
  logic [31:0] lfsr_q = 32'h83168552;
  logic [31:0] r;
  logic [13:0] tv;
  logic [3:0]  b;
  int          err_count = 0;
  int          n_tests = 0;
  int          n_pd = 0;
  int          n_ld = 0;
  int          n_aux = 0;
  int          pd0, ld0, aux0;
  int          cyc = 0;

  pfrc_host_model i_host (.ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));
  pfrc_top i_dut (.mclk(mclk), .rstn(rstn), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_latch(ser_latch), .chip_enable(chip_enable), .sw_powerup(sw_powerup),
    .main_cmp_evt(main_cmp_evt), .aux_cmp_evt(aux_cmp_evt), .fastlock_out_pin(pin_o),
    .fastlock_out_pin_oe(pin_oe), .fastlock_active(fl_act), .main_fastlock_pump_gain(gain),
    .cycle_slip_rate_sel(csr_sel), .main_pd_sample(pd_smp), .main_ld_strobe(ld_main),
    .aux_ld_strobe(ld_aux), .main_counter_reset(rst_tri[3]), .aux_counter_reset(rst_tri[2]),
    .main_pump_tristate(rst_tri[1]), .aux_pump_tristate(rst_tri[0]));

  always #50 mclk = ~mclk;
  always @(posedge mclk)
  begin
    n_pd <= n_pd + int'(pd_smp);
    n_ld <= n_ld + int'(ld_main);
    n_aux <= n_aux + int'(ld_aux);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rnd;
    lfsr_q = lfsr_next(lfsr_q);
    r = lfsr_q;
  endtask
  task automatic wr_fl(input logic [1:0] c, input logic [3:0] g, input logic [13:0] t,
    input logic s);
    i_host.send({c, g, t, ADDR_FASTLOCK}, s);
    tick(8);
  endtask
  task automatic wr_rt(input logic q, input logic [3:0] bits);
    i_host.send_reset(q, bits);
    tick(8);
  endtask
  task automatic evt(input int n, input logic m, input logic a);
    repeat (n)
    begin
      main_cmp_evt = m;
      aux_cmp_evt = a;
      tick(1);
      main_cmp_evt = 1'b0;
      aux_cmp_evt = 1'b0;
      tick(1);
    end
    tick(3);
  endtask
  function automatic logic [4:0] exp_gain(input logic [13:0] t, input logic [3:0] g);
    return (t == TOC_MANUAL || t >= TOC_TIMED_MIN) ? {1'b0, g} + 5'h01 : 5'h00;
  endfunction
  function automatic logic [1:0] exp_pin(input logic [13:0] t);
    return (t == TOC_HIZ) ? 2'b00 : (t == TOC_DRIVE_HIGH) ? 2'b11 : 2'b10;
  endfunction
  function automatic logic [3:0] exp_rt(input logic [3:0] v);
    return {v[2], v[3], v[0] | v[2], v[1] | v[3]};
  endfunction
  function automatic logic [15:0] exp_pd(input logic [1:0] c);
    return (c == CSR_OFF) ? 16'h0010 : (c == CSR_HALF) ? 16'h0008
         : (c == CSR_QUARTER) ? 16'h0004 : 16'h0001;
  endfunction

  initial
  begin
    tick(10);
    check("reset outputs", {rst_tri, pin_oe, gain}, {4'hF, 1'b0, 5'h00});
    tick(6);
    rstn = 1'b1;
    tick(12);
    check("idle resets", rst_tri, 4'h0);
    for (int t = 0; t < 4; t++)
    begin
      rnd();
      wr_fl(r[1:0], r[5:2], t[13:0], r[6]);
      check("pin", {pin_oe, pin_o & pin_oe}, exp_pin(t[13:0]));
      check("gain", gain, exp_gain(t[13:0], r[5:2]));
      check("csr", csr_sel, r[1:0]);
      evt(4, 1'b1, 1'b0);
      check("manual hold", fl_act, t == 1);
    end
    for (int k = 0; k < 2; k++)
    begin
      rnd();
      tv = TOC_TIMED_MIN + {12'h000, r[1:0]};
      wr_fl(CSR_OFF, k ? 4'hF : 4'h0, tv, k[0]);
      check("timed gain", gain, k ? 5'h10 : 5'h01);
      evt(2 * tv - 1, 1'b1, 1'b0);
      check("timed on", {fl_act, pin_oe, pin_o}, 3'b110);
      evt(1, 1'b1, 1'b0);
      check("timed off", {fl_act, pin_oe, gain}, 7'h00);
    end
    for (int c = 0; c < 4; c++)
    begin
      wr_fl(c[1:0], 4'h0, TOC_HIZ, 1'b0);
      pd0 = n_pd;
      evt(16, 1'b1, 1'b0);
      check("pd samples", 16'(n_pd - pd0), exp_pd(c[1:0]));
    end
    for (int q = 1; q >= 0; q--)
    begin
      wr_rt(q[0], 4'h0);
      ld0 = n_ld;
      aux0 = n_aux;
      evt(16, 1'b1, 1'b1);
      check("ld strobes", 16'(n_ld - ld0), q ? 16'h0004 : 16'h0010);
      check("aux strobes", 16'(n_aux - aux0), 16'h0010);
    end
    for (int i = 0; i < 6; i++)
    begin
      rnd();
      b = (i < 4) ? 4'h1 << i : r[3:0];
      wr_rt(1'b0, b);
      check("reset tri", rst_tri, exp_rt(b));
    end
    wr_rt(1'b0, 4'h0);
    i_host.send({RT_HIGH_FIXED, 1'b0, 5'h19, 4'hF, ADDR_RESET_TRI}, 1'b0);
    tick(8);
    check("bad fixed bits", rst_tri, 4'h0);
    i_host.send({CSR_OFF, 4'h3, TOC_MANUAL, 4'hE}, 1'b0);
    tick(8);
    check("bad address", {fl_act, gain}, 6'h00);
    sw_powerup = 1'b1;
    tick(1);
    sw_powerup = 1'b0;
    tick(2);
    check("sw power-up", rst_tri, 4'hF);
    tick(12);
    check("after sw power-up", rst_tri, 4'h0);
    chip_enable = 1'b1;
    tick(6);
    check("pin power-up", rst_tri, 4'hF);
    tick(15);
    check("after pin power-up", rst_tri, 4'h0);
    give_verdict();
  end
endmodule
